// ### pkg/reset_seq_pkg.sv
// Purpose: Constants for reset start-up sequencing and reset-cause flags
// Assumes: 100 MHz sys_clk, which is also the oscillator clock
// Notes:   Register offsets are byte addresses on the plain register port
// Function
// (R1) CPU waits for enabled power-up timer and released reset pin after power release.
// (R2) Power-up timer counts regardless of the reset pin level.
// (R3) Execution starts exactly 10 clocks after pin high with timer expired; code starts 13 clocks after the pin input rises.
// (R4) Fetch beyond program memory or into enabled storage area causes reset.
// (R5) Execution-violation reset drives its flag to 0; flag is 1 after power-up.
// (R6) Software writes execution-violation flag back to 1 to catch later violations.
// (R7) Reset updates only the cause flag of its own source; brown-out also sets stack, watchdog, pin and instruction flags inactive.
// (R8) Software may clear flags to inactive; hardware never does so itself. Brown-out reset here drives stack, watchdog, pin and instruction flags inactive.
// (R9) Software writing a flag active stores it but causes no reset.
// (R10) Software brown-out enable works only in mode 01; 1 after power-up.
// (R11) Brown-out ready reads 1 only when circuit is active and armed.
// (R12) Stack overflow sets its flag; 0 after power-up.
// (R13) Stack underflow sets its flag; 0 after power-up.
// (R14) Watchdog reset drives watchdog flag to 0; 1 after power-up.
// (R15) Pin reset drives pin flag to 0, running or asleep.
// (R16) Reset instruction drives its flag to 0; 1 after power-up.
// (R17) Power-on reset drives power-on flag to 0; other resets leave it.
// (R18) Timeout and power-down flags follow reset or wake kind.
// (R19) Reset loads PC 0; wake continues; interrupt wake with enable vectors 0004h.
// (R20) Stack faults reset only when stack reset enable is 1.
// (R21) Brown-out reset drives brown-out flag to 0; firmware may set it.
// (R22) CPU held while any enabled reset source stays asserted.
package reset_seq_pkg;
  localparam logic [11:0] BC_ADDR = 12'h811;
  localparam logic [11:0] RC_ADDR = 12'h813;
  localparam logic [11:0] EV_ADDR = 12'h814;
  localparam logic [11:0] PS_ADDR = 12'h815;

  localparam int BC_SWEN  = 7;
  localparam int BC_RDY   = 0;
  localparam int RC_OVF   = 7;
  localparam int RC_UNF   = 6;
  localparam int RC_WDT   = 4;
  localparam int RC_PIN   = 3;
  localparam int RC_INS   = 2;
  localparam int RC_POR   = 1;
  localparam int RC_BOR   = 0;
  localparam int EV_EXEC_VIOLATION_FLAG  = 1;
  localparam int PS_TO    = 1;
  localparam int PS_PD    = 0;

  localparam logic [7:0] RC_MASK  = 8'hdf;
  localparam logic [7:0] RC_POR_V = 8'h1d;
  localparam logic [7:0] RC_BOR_V = 8'h1c;
  localparam logic [7:0] RC_BORM  = 8'hdd;

  localparam logic [1:0] BOR_ON    = 2'h3;
  localparam logic [1:0] BOR_NOSLP = 2'h2;
  localparam logic [1:0] BOR_SW    = 2'h1;

  localparam logic [14:0] PC_RESET  = 15'h0000;
  localparam logic [14:0] PC_VECTOR = 15'h0004;
  localparam logic [14:0] PROG_END  = 15'h1000;
  localparam logic [14:0] SAF_START = 15'h0f80;

  localparam int CLK_MHZ       = 100;
  localparam int POWERUP_DELAY_TIMER_TIME_US  = 64000;
  localparam int POWERUP_DELAY_TIMER_CYC      = POWERUP_DELAY_TIMER_TIME_US * CLK_MHZ;
  localparam int START_OSC_CYC = 10;
  localparam logic [3:0] START_LAST = 4'(START_OSC_CYC - 1);

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10
  } seq_state_t;
endpackage

// ### design/reset_cause_startup_seq.sv
// Purpose: Start-up sequencer and reset-cause flag registers
// Assumes: resetn is the power-on reset; pin and analog inputs are async
// Notes:   Reads return data one cycle after the read strobe
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module reset_cause_startup_seq
  import reset_seq_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC
) (
  input  wire logic        sys_clk,             // System clock
  input  wire logic        resetn,              // Power-on reset, low
  input  wire logic        master_clear_pin_n,  // Reset pin, low resets
  input  wire logic        bor_trip,            // Supply below threshold
  input  wire logic        bor_circuit_rdy,     // Analog detector settled
  input  wire logic        pin_reset_en,        // Reset pin function on
  input  wire logic        powerup_delay_timer_en,             // Power-up timer on
  input  wire logic [1:0]  brownout_mode_cfg,   // Brown-out mode
  input  wire logic        stack_reset_enable,  // Stack faults reset
  input  wire logic        global_irq_enable,   // Interrupts enabled
  input  wire logic        cpu_sleep,           // CPU asleep
  input  wire logic        wdt_timeout,         // Watchdog expiry pulse
  input  wire logic        irq_wake,            // Interrupt wake pulse
  input  wire logic        reset_instr,         // Reset instruction pulse
  input  wire logic        stack_over,          // Call into full stack
  input  wire logic        stack_under,         // Return on empty stack
  input  wire logic        fetch_valid,         // Instruction fetched
  input  wire logic [14:0] fetch_addr,          // Fetch address
  input  wire logic        saf_enable,          // Storage area protected
  input  wire logic [11:0] reg_addr,            // Register address
  input  wire logic [7:0]  reg_wdata,           // Write data
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic        reg_rd,              // Read strobe
  output logic      [7:0]  reg_rdata,           // Read data
  output logic             cpu_reset_n,         // CPU held while low
  output logic             brownout_enable,     // Detector enable
  output logic             pc_load,             // Load PC pulse
  output logic      [14:0] pc_load_addr,        // PC value to load
  output logic             push_return,         // Push return address
  output logic             wake_resume          // Continue at PC+1
);

  // Async inputs: pin, trip, ready
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       pin_s;
  logic       trip_s;
  logic       rdy_s;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [22:0] powerup_delay_timer_cnt_q;
  logic        powerup_delay_timer_done_q;
  logic [3:0]  dly_cnt_q;

  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic       exec_violation_flag_q;
  logic       exec_violation_flag_d;
  logic       sw_brownout_enable_q;
  logic       sw_brownout_enable_d;
  logic       to_q;
  logic       to_d;
  logic       pd_q;
  logic       pd_d;

  logic running;
  logic bor_hit;
  logic pin_low;
  logic pin_rst;
  logic wdt_rst;
  logic wdt_wake;
  logic int_wake;
  logic ins_rst;
  logic exec_violation_flag_hit;
  logic stk_rst;
  logic run_reset;
  logic bor_ready;
  logic bor_wait;
  logic start_ok;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {master_clear_pin_n, bor_trip, bor_circuit_rdy};
      sync2_q <= sync1_q;
    end
  end

  assign pin_s  = sync2_q[2];
  assign trip_s = sync2_q[1];
  assign rdy_s  = sync2_q[0];

  // Detector enable per mode
  always_comb begin
    unique case (brownout_mode_cfg)
      BOR_ON:    brownout_enable = 1'b1;
      BOR_NOSLP: brownout_enable = !cpu_sleep;
      BOR_SW:    brownout_enable = sw_brownout_enable_q; // R10
      default:   brownout_enable = 1'b0;
    endcase
  end

  assign bor_ready = brownout_enable && rdy_s; // R11
  assign bor_hit   = bor_ready && trip_s;

  // Modes 11 and 10 delay start-up until detector is ready
  assign bor_wait = (brownout_mode_cfg == BOR_ON || brownout_mode_cfg == BOR_NOSLP)
                    && !bor_ready;

  assign running  = (state_q == ST_RUN);
  assign pin_low  = pin_reset_en && !pin_s;
  assign pin_rst  = running && pin_low;
  assign wdt_rst  = running && !cpu_sleep && wdt_timeout;
  assign wdt_wake = running && cpu_sleep && wdt_timeout;
  assign int_wake = running && cpu_sleep && irq_wake && !wdt_timeout;
  assign ins_rst  = running && !cpu_sleep && reset_instr;
  assign exec_violation_flag_hit = running && fetch_valid &&
                    (fetch_addr >= PROG_END || (saf_enable && fetch_addr >= SAF_START)); // R4
  assign stk_rst  = running && stack_reset_enable && (stack_over || stack_under); // R20
  assign run_reset = pin_rst || wdt_rst || ins_rst || exec_violation_flag_hit || stk_rst;

  // Power-up timer runs while the pin is low
  assign start_ok = powerup_delay_timer_done_q && !pin_low && !bor_wait && !bor_hit; // R1 R22

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      powerup_delay_timer_cnt_q  <= 23'h0;
      powerup_delay_timer_done_q <= 1'b0;
    end else if (bor_hit) begin
      powerup_delay_timer_cnt_q  <= 23'h0;
      powerup_delay_timer_done_q <= 1'b0;
    end else if (!powerup_delay_timer_done_q) begin
      if (!powerup_delay_timer_en || powerup_delay_timer_cnt_q == 23'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin // R2
        powerup_delay_timer_done_q <= 1'b1;
      end
      powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q + 23'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_START: begin
        if (start_ok) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!start_ok) begin
          state_d = ST_START; // R22
        end else if (dly_cnt_q == START_LAST) begin
          state_d = ST_RUN; // R3
        end
      end
      ST_RUN: begin
        if (run_reset || bor_hit) begin
          state_d = ST_START;
        end
      end
      default: state_d = ST_START;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_START;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dly_cnt_q <= 4'h0;
    end else if (state_q == ST_DELAY && state_d == ST_DELAY) begin
      dly_cnt_q <= dly_cnt_q + 4'h1; // R3
    end else begin
      dly_cnt_q <= 4'h0;
    end
  end

  assign cpu_reset_n = running;

  // Cause flags: software first, hardware events override
  always_comb begin
    flags_d  = flags_q;
    exec_violation_flag_d   = exec_violation_flag_q;
    sw_brownout_enable_d = sw_brownout_enable_q;
    to_d     = to_q;
    pd_d     = pd_q;
    if (reg_wr && reg_addr == RC_ADDR) begin
      flags_d = reg_wdata & RC_MASK; // R8 R9
    end
    if (reg_wr && reg_addr == EV_ADDR) begin
      exec_violation_flag_d = reg_wdata[EV_EXEC_VIOLATION_FLAG]; // R6 R9
    end
    if (reg_wr && reg_addr == BC_ADDR) begin
      sw_brownout_enable_d = reg_wdata[BC_SWEN];
    end
    if (stack_over && running) begin
      flags_d[RC_OVF] = 1'b1; // R12
    end
    if (stack_under && running) begin
      flags_d[RC_UNF] = 1'b1; // R13
    end
    if (wdt_rst) begin
      flags_d[RC_WDT] = 1'b0; // R14
      to_d = 1'b0; // R18
    end
    if (wdt_wake) begin
      to_d = 1'b0; // R18
      pd_d = 1'b0;
    end
    if (int_wake) begin
      to_d = 1'b1; // R18
      pd_d = 1'b0;
    end
    if (pin_rst) begin
      flags_d[RC_PIN] = 1'b0; // R15
      if (cpu_sleep) begin
        to_d = 1'b1; // R18
        pd_d = 1'b0;
      end
    end
    if (ins_rst) begin
      flags_d[RC_INS] = 1'b0; // R16
    end
    if (exec_violation_flag_hit) begin
      exec_violation_flag_d = 1'b0; // R5 R7
    end
    if (bor_hit) begin
      flags_d  = (flags_d & ~RC_BORM) | RC_BOR_V; // R21
      to_d     = 1'b1;
      pd_d     = 1'b1;
      sw_brownout_enable_d = 1'b1; // R10
    end
  end

  // Power-on values: power-on flag driven 0, others at defaults
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= RC_POR_V; // R17
      exec_violation_flag_q  <= 1'b1; // R5
    end else begin
      flags_q <= flags_d; // R7
      exec_violation_flag_q  <= exec_violation_flag_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sw_brownout_enable_q <= 1'b1;
    end else begin
      sw_brownout_enable_q <= sw_brownout_enable_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      to_q <= 1'b1; // R18
      pd_q <= 1'b1;
    end else begin
      to_q <= to_d;
      pd_q <= pd_d;
    end
  end

  // Program counter steering
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_load      <= 1'b0;
      pc_load_addr <= PC_RESET;
      push_return  <= 1'b0;
      wake_resume  <= 1'b0;
    end else begin
      pc_load     <= 1'b0;
      push_return <= 1'b0;
      wake_resume <= 1'b0;
      if (run_reset || bor_hit) begin
        pc_load      <= 1'b1; // R19
        pc_load_addr <= PC_RESET;
      end else if (wdt_wake || int_wake) begin
        wake_resume <= 1'b1; // R19
        if (int_wake && global_irq_enable) begin
          pc_load      <= 1'b1;
          pc_load_addr <= PC_VECTOR;
          push_return  <= 1'b1;
        end
      end
    end
  end

  // Register read port
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        BC_ADDR: reg_rdata <= {sw_brownout_enable_q, 6'h00, bor_ready}; // R11
        RC_ADDR: reg_rdata <= flags_q & RC_MASK;
        EV_ADDR: reg_rdata <= {6'h00, exec_violation_flag_q, 1'b0};
        PS_ADDR: reg_rdata <= {6'h00, to_q, pd_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### tb/reset_cause_startup_seq_assertions.sv
// Purpose: Port assertions for the reset sequencer
// Assumes: One clock domain, resetn async low
// Notes:   Bound to the sequencer below
`timescale 1ns/100ps
`default_nettype none
module rcs_checker
  import reset_seq_pkg::*;
(
  input wire logic        sys_clk,            // Clock
  input wire logic        resetn,             // Power reset
  input wire logic        master_clear_pin_n, // Pin
  input wire logic        pin_reset_en,       // Pin on
  input wire logic [1:0]  brownout_mode_cfg,  // Mode
  input wire logic        global_irq_enable,  // Irq on
  input wire logic        cpu_sleep,          // Asleep
  input wire logic        wdt_timeout,        // Watchdog
  input wire logic        irq_wake,           // Wake
  input wire logic        reset_instr,        // Reset op
  input wire logic        fetch_valid,        // Fetch
  input wire logic [14:0] fetch_addr,         // Address
  input wire logic        cpu_reset_n,        // Run
  input wire logic        brownout_enable,    // Detector on
  input wire logic        pc_load,            // Load
  input wire logic [14:0] pc_load_addr,       // Load value
  input wire logic        push_return,        // Push
  input wire logic        wake_resume         // Resume
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wdt_reset_a: assert property (wdt_timeout && cpu_reset_n && !cpu_sleep |=>
    pc_load && pc_load_addr == PC_RESET && !cpu_reset_n) else $error("watchdog reset");
  start_gap_a: assert property ($rose(cpu_reset_n) && pin_reset_en |->
    $past(master_clear_pin_n, 12)) else $error("start too early after pin");
  pin_hold_a: assert property (pin_reset_en && !master_clear_pin_n |->
    ##[1:4] !cpu_reset_n) else $error("pin low did not hold cpu");
  fetch_bad_a: assert property (fetch_valid && cpu_reset_n && fetch_addr >= PROG_END |=>
    !cpu_reset_n) else $error("no reset on bad fetch");
  bor_fixed_a: assert property (brownout_mode_cfg[1] == brownout_mode_cfg[0] |->
    brownout_enable == brownout_mode_cfg[1]) else $error("detector enable wrong");
  irq_push_a: assert property (irq_wake && cpu_sleep && cpu_reset_n && global_irq_enable
    |=> push_return && cpu_reset_n) else $error("no push on wake");
  irq_nopush_a: assert property (irq_wake && cpu_sleep && !global_irq_enable |=>
    !push_return) else $error("push without enable");
  instr_reset_a: assert property (reset_instr && cpu_reset_n && !cpu_sleep |=>
    pc_load && !cpu_reset_n) else $error("reset instruction ignored");
  wake_resume_a: assert property (cpu_sleep && cpu_reset_n && (irq_wake || wdt_timeout) |=>
    wake_resume && cpu_reset_n) else $error("wake did not resume");
endmodule

bind reset_cause_startup_seq rcs_checker chk (
  .sys_clk, .resetn, .master_clear_pin_n, .pin_reset_en, .brownout_mode_cfg,
  .global_irq_enable, .cpu_sleep, .wdt_timeout, .irq_wake, .reset_instr, .fetch_valid,
  .fetch_addr, .cpu_reset_n, .brownout_enable, .pc_load, .pc_load_addr, .push_return,
  .wake_resume
);
`default_nettype wire

// ### tb/pin_supply_model.sv
// Purpose: Reset pin and supply detector seen from outside
// Assumes: Detector arms WARM clocks after being enabled
// Notes:   Supply dips only while drop is high
`timescale 1ns/100ps
`default_nettype none
module pin_supply_model #(
  parameter int WARM = 6
) (
  input  wire logic clk,      // Clock
  input  wire logic hold_low, // Press pin
  input  wire logic det_en,   // Detector on
  input  wire logic drop,     // Supply dips
  output logic      pin_n,    // Pin level
  output logic      trip,     // Supply low
  output logic      rdy       // Detector armed
);
  // Known start so the warm-up count never stays unknown
  int cnt = 0;
  // Weak pull-up lifts the released pin
  assign pin_n = !hold_low;
  assign trip  = drop;
  assign rdy   = det_en && cnt >= WARM;
  always_ff @(posedge clk) begin
    cnt <= det_en ? (cnt < WARM ? cnt + 1 : cnt) : 0;
  end
endmodule
`default_nettype wire

// ### tb/reset_cause_startup_seq_tb.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Power-up timer shortened to PW clocks
// Notes:   Event pulses: 0 wdt, 1 irq, 2 reset op, 3 ovf, 4 unf, 5 fetch
`timescale 1ns/100ps
`default_nettype none
`define CK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module reset_cause_startup_seq_tb
  import reset_seq_pkg::*;
;
  localparam int PW = 20;
  logic        sys_clk, resetn, hold, master_clear_pin_n, bor_trip, bor_circuit_rdy, e;
  logic        cpu_sleep, global_irq_enable, stack_reset_enable, saf_enable;
  logic        pin_reset_en, powerup_delay_timer_en, drop;
  logic        reg_wr, reg_rd, cpu_reset_n, brownout_enable;
  logic [5:0]  ev;
  logic [1:0]  brownout_mode_cfg;
  logic [14:0] fetch_addr;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  int          fails, n_compared, n;

  reset_cause_startup_seq #(.POWERUP_DELAY_TIMER_CYCLES(PW)) DUT (
    .sys_clk, .resetn, .master_clear_pin_n, .bor_trip, .bor_circuit_rdy, .pin_reset_en,
    .powerup_delay_timer_en, .brownout_mode_cfg, .stack_reset_enable, .global_irq_enable, .cpu_sleep,
    .wdt_timeout(ev[0]), .irq_wake(ev[1]), .reset_instr(ev[2]), .stack_over(ev[3]),
    .stack_under(ev[4]), .fetch_valid(ev[5]), .fetch_addr, .saf_enable, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_reset_n, .brownout_enable, .pc_load(),
    .pc_load_addr(), .push_return(), .wake_resume()
  );
  pin_supply_model #(.WARM(6)) partner (
    .clk(sys_clk), .hold_low(hold), .det_en(brownout_enable), .drop(drop),
    .pin_n(master_clear_pin_n),
    .trip(bor_trip), .rdy(bor_circuit_rdy)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CK(reg_rdata, x)
    @(posedge sys_clk);
  endtask
  task automatic pls(input int i);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev <= '0;
    @(posedge sys_clk);
  endtask
  // Counts clock cycles, sampled at falling edges, until the cpu runs
  task automatic wrun(output int c);
    c = 0;
    while (cpu_reset_n !== 1'b1 && c < 400) begin
      @(negedge sys_clk);
      c++;
    end
    @(posedge sys_clk);
    if (c >= 400) begin
      fails++;
      end_sim;
    end
  endtask

  initial begin
    {resetn, reg_wr, reg_rd, cpu_sleep, stack_reset_enable, saf_enable, ev} = '0;
    {reg_addr, reg_wdata, fetch_addr, n, fails, n_compared} = '0;
    hold = 1'b1;
    {pin_reset_en, powerup_delay_timer_en, drop} = 3'b110;
    global_irq_enable = 1'b1;
    brownout_mode_cfg = BOR_ON;
    step(5);
    resetn <= 1'b1;
    step(PW + 20);
    `CK(cpu_reset_n, 1'b0)
    hold <= 1'b0;
    wrun(n);
    `CK(n, START_OSC_CYC + 4)
    rd(RC_ADDR, RC_POR_V);
    rd(EV_ADDR, 8'h02);
    rd(PS_ADDR, 8'h03);
    rd(BC_ADDR, 8'h81);
    rd(12'h812, 8'h00);
    pls(0);
    wrun(n);
    rd(RC_ADDR, 8'h0d);
    rd(PS_ADDR, 8'h01);
    wr(RC_ADDR, 8'hff);
    `CK(cpu_reset_n, 1'b1)
    rd(RC_ADDR, 8'hdf);
    wr(RC_ADDR, 8'h1f);
    pls(2);
    wrun(n);
    rd(RC_ADDR, 8'h1b);
    hold <= 1'b1;
    step(6);
    hold <= 1'b0;
    wrun(n);
    rd(RC_ADDR, 8'h13);
    pls(3);
    `CK(cpu_reset_n, 1'b1)
    rd(RC_ADDR, 8'h93);
    stack_reset_enable <= 1'b1;
    pls(4);
    `CK(cpu_reset_n, 1'b0)
    wrun(n);
    rd(RC_ADDR, 8'hd3);
    for (int i = 0; i < 2; i++) begin
      saf_enable <= i[0];
      fetch_addr <= i ? SAF_START : PROG_END;
      pls(5);
      wrun(n);
      rd(EV_ADDR, 8'h00);
      wr(EV_ADDR, 8'h02);
      rd(EV_ADDR, 8'h02);
    end
    rd(RC_ADDR, 8'hd3);
    cpu_sleep <= 1'b1;
    pls(1);
    rd(PS_ADDR, 8'h02);
    pls(0);
    rd(PS_ADDR, 8'h00);
    global_irq_enable <= 1'b0;
    pls(1);
    rd(PS_ADDR, 8'h02);
    cpu_sleep <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      brownout_mode_cfg <= m[2:1];
      e = m[2] | (m[2:1] == 2'h1 & m[0]);
      wr(BC_ADDR, {m[0], 7'h00});
      step(12);
      `CK(brownout_enable, e)
      rd(BC_ADDR, {m[0], 6'h00, e});
    end
    drop <= 1'b1;
    step(4);
    `CK(cpu_reset_n, 1'b0)
    drop <= 1'b0;
    wrun(n);
    `CK(n, PW + START_OSC_CYC + 4)
    rd(RC_ADDR, 8'h1e);
    rd(PS_ADDR, 8'h03);
    resetn <= 1'b0;
    step(2);
    resetn <= 1'b1;
    wrun(n);
    `CK(n, PW + START_OSC_CYC + 2)
    rd(RC_ADDR, RC_POR_V);
    rd(PS_ADDR, 8'h03);
    powerup_delay_timer_en      <= 1'b0;
    pin_reset_en <= 1'b0;
    hold         <= 1'b1;
    resetn       <= 1'b0;
    step(2);
    resetn <= 1'b1;
    wrun(n);
    `CK(n, START_OSC_CYC + 4)
    pin_reset_en <= 1'b1;
    step(6);
    `CK(cpu_reset_n, 1'b0)
    rd(RC_ADDR, 8'h15);
    end_sim;
  end
endmodule
`default_nettype wire
